// ### psrc_pkg.sv
// psrc_pkg: shared constants and types of the pressure setpoint relay control block.
// assumes a 32-bit classic wishbone slave port and one 100 MHz system clock.
package psrc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PSRC_PW = 24; // pressure word, one count = one mTORR equivalent
	localparam int PSRC_NEV = 5; // number of sticky event bits

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PSRC_OFF_UNITS = 8'h00;
	localparam logic [7:0] PSRC_OFF_A_ON = 8'h08;
	localparam logic [7:0] PSRC_OFF_A_OFF = 8'h0c;
	localparam logic [7:0] PSRC_OFF_B_ON = 8'h10;
	localparam logic [7:0] PSRC_OFF_B_OFF = 8'h14;
	localparam logic [7:0] PSRC_OFF_LIN_MIN = 8'h18;
	localparam logic [7:0] PSRC_OFF_LIN_MAX = 8'h1c;
	localparam logic [7:0] PSRC_OFF_NODE = 8'h20;
	localparam logic [7:0] PSRC_OFF_ZERO = 8'h24;
	localparam logic [7:0] PSRC_OFF_SPAN = 8'h28;
	localparam logic [7:0] PSRC_OFF_STATUS = 8'h2c;
	localparam logic [7:0] PSRC_OFF_MASK = 8'h30;
	localparam logic [7:0] PSRC_OFF_RELAY = 8'h34;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PSRC_NODE_LO_LSB = 0;
	localparam int PSRC_NODE_HI_LSB = 4;
	localparam int PSRC_NODE_ID_LSB = 8;
	localparam int PSRC_EV_RELAY_A = 0;
	localparam int PSRC_EV_RELAY_B = 1;
	localparam int PSRC_EV_BLOCKED = 2;
	localparam int PSRC_EV_DEFAULTS = 3;
	localparam int PSRC_EV_ZERO = 4;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [PSRC_PW-1:0] PSRC_RST_ENERGIZE = 24'h000064; // 100 mTORR
	localparam logic [PSRC_PW-1:0] PSRC_RST_RELEASE = 24'h0000c8; // 200 mTORR
	localparam logic [PSRC_PW-1:0] PSRC_RST_LIN_MIN = 24'h000001; // 1 mTORR
	localparam logic [PSRC_PW-1:0] PSRC_RST_LIN_MAX = 24'h0003e8; // 1 TORR
	localparam logic [PSRC_PW-1:0] PSRC_RST_ZERO = 24'h000000;
	localparam logic [PSRC_PW-1:0] PSRC_RST_SPAN = 24'h0b9900; // arbitrary span start near atmosphere
	localparam logic [3:0] PSRC_RST_NODE_LO = 4'h1;
	localparam logic [3:0] PSRC_RST_NODE_HI = 4'h0;
	localparam logic [PSRC_NEV-1:0] PSRC_RST_MASK = 5'h00;

	// ----------------------------------------------------------------
	// front key positions
	// ----------------------------------------------------------------
	localparam int PSRC_KEY_SCROLL = 0;
	localparam int PSRC_KEY_STORE = 1;
	localparam int PSRC_KEY_UP = 2; // also the zero_capture_key on the zero screen
	localparam int PSRC_KEY_DOWN = 3;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PSRC_UNIT_TORR = 2'h0,
		PSRC_UNIT_MBAR = 2'h1,
		PSRC_UNIT_PA = 2'h2
	} psrc_unit_e;

	typedef enum logic [3:0] {
		PSRC_SCR_MAIN = 4'h1,
		PSRC_SCR_UNITS = 4'h2,
		PSRC_SCR_ZERO = 4'h4,
		PSRC_SCR_SPAN = 4'h8
	} psrc_screen_e;

endpackage : psrc_pkg

// ### psrc_relay.sv
// psrc_relay: one setpoint relay channel with a hysteresis band.
// assumes thresholds already ordered energize < release by the register logic.
`timescale 1ns/10ps
module psrc_relay
	import psrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [PSRC_PW-1:0] pressure_i,
	input wire logic [PSRC_PW-1:0] energize_i,
	input wire logic [PSRC_PW-1:0] release_i,
	input wire logic inhibit_i,
	output logic energized_o,
	output logic changed_o
);

	typedef struct packed {
		logic coil;
	} psrc_relay_s;

	psrc_relay_s st_r;
	psrc_relay_s st_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// inhibit is checked first so a disabled relay can never chatter
	always_comb begin
		st_nxt = st_r;
		if (inhibit_i) begin
			st_nxt.coil = 1'b0;
		end else if (pressure_i < energize_i) begin
			st_nxt.coil = 1'b1;
		end else if (pressure_i > release_i) begin
			st_nxt.coil = 1'b0;
		end
		// inside the band the coil keeps its state
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign energized_o = st_r.coil;
	assign changed_o = ce_i & (st_nxt.coil != st_r.coil);

endmodule : psrc_relay

// ### psrc_top.sv
// psrc_top: setpoint relays, relay inhibit, node address and front panel programming.
// assumes pressure and raw sensor words come from logic on clk_i; keys and inhibit are pins.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
module psrc_top
	import psrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// measurement side
	input wire logic [PSRC_PW-1:0] pressure_i,
	input wire logic [PSRC_PW-1:0] sensor_raw_i,
	output logic [PSRC_PW-1:0] zero_point_o,
	output logic [PSRC_PW-1:0] span_cal_o,
	output logic [PSRC_PW-1:0] lin_min_o,
	output logic [PSRC_PW-1:0] lin_max_o,
	output logic [1:0] units_o,
	// serial side
	output logic [7:0] node_id_o,
	// pins
	input wire logic [3:0] keys_i,
	input wire logic relay_inhibit_n_i,
	output logic relay_a_o,
	output logic relay_b_o,
	output logic irq_o
);

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [1:0] units;
		logic [1:0] edit_units;
		logic [PSRC_PW-1:0] a_on;
		logic [PSRC_PW-1:0] a_off;
		logic [PSRC_PW-1:0] b_on;
		logic [PSRC_PW-1:0] b_off;
		logic [PSRC_PW-1:0] lin_min;
		logic [PSRC_PW-1:0] lin_max;
		logic [PSRC_PW-1:0] zero;
		logic [PSRC_PW-1:0] span;
		logic [PSRC_PW-1:0] span_edit;
		logic [3:0] node_lo;
		logic [3:0] node_hi;
		logic [PSRC_NEV-1:0] irq_st;
		logic [PSRC_NEV-1:0] irq_mask;
		psrc_screen_e screen;
		logic [3:0] key_s1;
		logic [3:0] key_s2;
		logic [3:0] key_prev;
		logic inh_s1;
		logic inh_s2;
	} psrc_state_s;

	psrc_state_s st_r;
	psrc_state_s st_nxt;

	logic relay_a_chg;
	logic relay_b_chg;
	logic inhibit;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte-lane merge of a write into the present register value
	function automatic logic [31:0] psrc_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : psrc_merge

	// register readback, also the base for partial writes
	function automatic logic [31:0] psrc_read(input psrc_state_s s, input logic [7:0] adr,
			input logic ra, input logic rb, input logic inh);
		logic [31:0] r;
		r = 32'h00000000;
		case (adr)
			PSRC_OFF_UNITS: r[1:0] = s.units;
			PSRC_OFF_A_ON: r[PSRC_PW-1:0] = s.a_on;
			PSRC_OFF_A_OFF: r[PSRC_PW-1:0] = s.a_off;
			PSRC_OFF_B_ON: r[PSRC_PW-1:0] = s.b_on;
			PSRC_OFF_B_OFF: r[PSRC_PW-1:0] = s.b_off;
			PSRC_OFF_LIN_MIN: r[PSRC_PW-1:0] = s.lin_min;
			PSRC_OFF_LIN_MAX: r[PSRC_PW-1:0] = s.lin_max;
			PSRC_OFF_NODE: begin
				r[PSRC_NODE_LO_LSB +: 4] = s.node_lo;
				r[PSRC_NODE_HI_LSB +: 4] = s.node_hi;
				r[PSRC_NODE_ID_LSB +: 8] = {s.node_hi, s.node_lo};
			end
			PSRC_OFF_ZERO: r[PSRC_PW-1:0] = s.zero;
			PSRC_OFF_SPAN: r[PSRC_PW-1:0] = s.span;
			PSRC_OFF_STATUS: r[PSRC_NEV-1:0] = s.irq_st;
			PSRC_OFF_MASK: r[PSRC_NEV-1:0] = s.irq_mask;
			PSRC_OFF_RELAY: r[2:0] = {inh, rb, ra};
			default: r = 32'h00000000; // unmapped reads as zero, still acked
		endcase
		return r;
	endfunction : psrc_read

	// ----------------------------------------------------------------
	// relay channels
	// ----------------------------------------------------------------
	// only the synchronised inhibit level reaches the relays
	assign inhibit = ~st_r.inh_s2;

	// two independent channels; the small connector simply leaves relay_b_o unwired
	psrc_relay u_relay_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pressure_i(pressure_i),
		.energize_i(st_r.a_on),
		.release_i(st_r.a_off),
		.inhibit_i(inhibit),
		.energized_o(relay_a_o),
		.changed_o(relay_a_chg)
	);

	psrc_relay u_relay_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pressure_i(pressure_i),
		.energize_i(st_r.b_on),
		.release_i(st_r.b_off),
		.inhibit_i(inhibit),
		.energized_o(relay_b_o),
		.changed_o(relay_b_chg)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] kp;
		logic req;
		logic wr;
		logic [31:0] wv;
		logic [PSRC_PW-1:0] wp;
		logic [1:0] new_units;
		logic unit_chg;
		logic [PSRC_NEV-1:0] ev;
		logic [PSRC_NEV-1:0] clr;

		kp = 4'h0;
		req = 1'b0;
		wr = 1'b0;
		wv = 32'h00000000;
		wp = '0;
		new_units = 2'h0;
		unit_chg = 1'b0;
		ev = '0;
		clr = '0;
		st_nxt = st_r;

		// pin synchronisers; only stage two and, for the keys, the key_prev edge flop are looked at
		st_nxt.key_s1 = keys_i;
		st_nxt.key_s2 = st_r.key_s1;
		st_nxt.key_prev = st_r.key_s2;
		st_nxt.inh_s1 = relay_inhibit_n_i;
		st_nxt.inh_s2 = st_r.inh_s1;
		kp = st_r.key_s2 & ~st_r.key_prev; // one pulse per key press
		new_units = st_r.units;

		// front panel menu
		case (st_r.screen)
			PSRC_SCR_MAIN: begin
				if (kp != 4'h0) begin
					st_nxt.screen = PSRC_SCR_UNITS;
					st_nxt.edit_units = st_r.units;
				end
			end
			PSRC_SCR_UNITS: begin
				if (kp[PSRC_KEY_STORE]) begin
					new_units = st_r.edit_units;
					st_nxt.screen = PSRC_SCR_MAIN;
				end else if (kp[PSRC_KEY_SCROLL]) begin
					st_nxt.screen = PSRC_SCR_ZERO;
				end else if (kp[PSRC_KEY_UP]) begin
					st_nxt.edit_units = (st_r.edit_units == PSRC_UNIT_PA) ?
						PSRC_UNIT_TORR : st_r.edit_units + 2'h1;
				end else if (kp[PSRC_KEY_DOWN]) begin
					st_nxt.edit_units = (st_r.edit_units == PSRC_UNIT_TORR) ?
						PSRC_UNIT_PA : st_r.edit_units - 2'h1;
				end
			end
			PSRC_SCR_ZERO: begin
				if (kp[PSRC_KEY_UP]) begin
					st_nxt.zero = sensor_raw_i;
					ev[PSRC_EV_ZERO] = 1'b1;
				end
				if (kp[PSRC_KEY_STORE]) begin
					st_nxt.screen = PSRC_SCR_MAIN;
				end else if (kp[PSRC_KEY_SCROLL]) begin
					st_nxt.screen = PSRC_SCR_SPAN;
					st_nxt.span_edit = st_r.span;
				end
			end
			PSRC_SCR_SPAN: begin
				if (kp[PSRC_KEY_STORE]) begin
					st_nxt.span = st_r.span_edit;
					st_nxt.screen = PSRC_SCR_MAIN;
				end else if (kp[PSRC_KEY_SCROLL]) begin
					st_nxt.screen = PSRC_SCR_UNITS; // edits on this screen are dropped
					st_nxt.edit_units = st_r.units;
				end else if (kp[PSRC_KEY_UP]) begin
					st_nxt.span_edit = st_r.span_edit + 24'h000001;
				end else if (kp[PSRC_KEY_DOWN]) begin
					st_nxt.span_edit = st_r.span_edit - 24'h000001;
				end
			end
			default: begin
				st_nxt.screen = PSRC_SCR_MAIN;
			end
		endcase

		// wishbone: one wait state, the write lands on the edge that sees ack
		req = wb_cyc_i & wb_stb_i;
		wr = req & wb_we_i & st_r.ack;
		wv = psrc_merge(psrc_read(st_r, wb_adr_i, relay_a_o, relay_b_o, inhibit),
			wb_dat_i, wb_sel_i);
		wp = wv[PSRC_PW-1:0];
		st_nxt.ack = req & ~st_r.ack;
		if (req & ~st_r.ack) begin
			st_nxt.dat = psrc_read(st_r, wb_adr_i, relay_a_o, relay_b_o, inhibit);
		end

		if (wr) begin
			case (wb_adr_i)
				PSRC_OFF_UNITS: begin
					if (wv[1:0] != 2'h3) begin
						new_units = wv[1:0];
					end
				end
				PSRC_OFF_A_ON: begin
					if (wp < st_r.a_off) begin
						st_nxt.a_on = wp;
					end else begin
						ev[PSRC_EV_BLOCKED] = 1'b1;
					end
				end
				PSRC_OFF_A_OFF: begin
					if (wp > st_r.a_on) begin
						st_nxt.a_off = wp;
					end else begin
						ev[PSRC_EV_BLOCKED] = 1'b1;
					end
				end
				PSRC_OFF_B_ON: begin
					if (wp < st_r.b_off) begin
						st_nxt.b_on = wp;
					end else begin
						ev[PSRC_EV_BLOCKED] = 1'b1;
					end
				end
				PSRC_OFF_B_OFF: begin
					if (wp > st_r.b_on) begin
						st_nxt.b_off = wp;
					end else begin
						ev[PSRC_EV_BLOCKED] = 1'b1;
					end
				end
				PSRC_OFF_LIN_MIN: st_nxt.lin_min = wp;
				PSRC_OFF_LIN_MAX: st_nxt.lin_max = wp;
				PSRC_OFF_NODE: begin
					st_nxt.node_lo = wv[PSRC_NODE_LO_LSB +: 4];
					st_nxt.node_hi = wv[PSRC_NODE_HI_LSB +: 4];
				end
				PSRC_OFF_ZERO: st_nxt.zero = wp;
				PSRC_OFF_SPAN: st_nxt.span = wp;
				PSRC_OFF_STATUS: clr = wb_sel_i[0] ? wb_dat_i[PSRC_NEV-1:0] : '0; // unselected lane clears none
				PSRC_OFF_MASK: st_nxt.irq_mask = wv[PSRC_NEV-1:0];
				default: begin
					st_nxt.units = st_r.units; // unmapped writes are dropped
				end
			endcase
		end

		// unit change wipes thresholds and linear endpoints back to torr defaults
		unit_chg = (new_units != st_r.units);
		if (unit_chg) begin
			st_nxt.units = new_units;
			st_nxt.a_on = PSRC_RST_ENERGIZE;
			st_nxt.b_on = PSRC_RST_ENERGIZE;
			st_nxt.a_off = PSRC_RST_RELEASE;
			st_nxt.b_off = PSRC_RST_RELEASE;
			st_nxt.lin_min = PSRC_RST_LIN_MIN;
			st_nxt.lin_max = PSRC_RST_LIN_MAX;
			ev[PSRC_EV_DEFAULTS] = 1'b1;
		end

		// sticky events: a set in the clearing cycle survives
		ev[PSRC_EV_RELAY_A] = relay_a_chg;
		ev[PSRC_EV_RELAY_B] = relay_b_chg;
		st_nxt.irq_st = (st_r.irq_st & ~clr) | ev;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// everything holds while ce_i is low, synchronisers included
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.ack <= 1'b0;
			st_r.dat <= 32'h00000000;
			st_r.units <= PSRC_UNIT_TORR;
			st_r.edit_units <= PSRC_UNIT_TORR;
			st_r.a_on <= PSRC_RST_ENERGIZE;
			st_r.b_on <= PSRC_RST_ENERGIZE;
			st_r.a_off <= PSRC_RST_RELEASE;
			st_r.b_off <= PSRC_RST_RELEASE;
			st_r.lin_min <= PSRC_RST_LIN_MIN;
			st_r.lin_max <= PSRC_RST_LIN_MAX;
			st_r.zero <= PSRC_RST_ZERO;
			st_r.span <= PSRC_RST_SPAN;
			st_r.span_edit <= PSRC_RST_SPAN;
			st_r.node_lo <= PSRC_RST_NODE_LO;
			st_r.node_hi <= PSRC_RST_NODE_HI;
			st_r.irq_st <= '0;
			st_r.irq_mask <= PSRC_RST_MASK;
			st_r.screen <= PSRC_SCR_MAIN;
			st_r.key_s1 <= 4'h0;
			st_r.key_s2 <= 4'h0;
			st_r.key_prev <= 4'h0;
			st_r.inh_s1 <= 1'b1;
			st_r.inh_s2 <= 1'b1;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = st_r.ack & wb_cyc_i & wb_stb_i;
	assign wb_dat_o = st_r.dat;
	assign node_id_o = {st_r.node_hi, st_r.node_lo};
	assign zero_point_o = st_r.zero;
	assign span_cal_o = st_r.span;
	assign lin_min_o = st_r.lin_min;
	assign lin_max_o = st_r.lin_max;
	assign units_o = st_r.units;
	assign irq_o = |(st_r.irq_st & st_r.irq_mask);

endmodule : psrc_top

// ### psrc_plant.sv
// psrc_plant: chamber model feeding pressure and raw sensor words to the block.
// assumes the bench sets a target pressure and picks prompt or slow pumping.
`timescale 1ns/10ps
module psrc_plant
	import psrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic [PSRC_PW-1:0] target_i,
	output logic [PSRC_PW-1:0] pressure_o,
	output logic [PSRC_PW-1:0] raw_o
);
	// ----
	// chamber
	// ----
	// slow pumping walks one count a cycle so every threshold crossing is seen
	always_ff @(posedge clk_i) begin
		if (!slow_i || pressure_o == target_i) begin
			pressure_o <= target_i;
		end else if (pressure_o < target_i) begin
			pressure_o <= pressure_o + 24'h000001;
		end else begin
			pressure_o <= pressure_o - 24'h000001;
		end
	end
	// raw word carries an offset so a captured zero differs from the pressure
	assign raw_o = pressure_o + 24'h000123;
endmodule : psrc_plant

// ### psrc_checker.sv
// psrc_checker: concurrent checks on the ports of psrc_top.
// assumes one clock domain and the synchronous high reset of the block.
`timescale 1ns/10ps
module psrc_checker
	import psrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic [PSRC_PW-1:0] pressure_i,
	input wire logic [PSRC_PW-1:0] sensor_raw_i,
	input wire logic [PSRC_PW-1:0] zero_point_o,
	input wire logic [PSRC_PW-1:0] lin_max_o,
	input wire logic [1:0] units_o,
	input wire logic [7:0] node_id_o,
	input wire logic [3:0] keys_i,
	input wire logic relay_inhibit_n_i,
	input wire logic relay_a_o,
	input wire logic relay_b_o
);
	// ----
	// sequences
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// inhibit pin held low long enough to pass the two sync flops
	sequence inh_low_s;
		(ce_i && !relay_inhibit_n_i) [*3];
	endsequence
	// nothing that could move a relay for long enough that it has settled
	sequence quiet_s;
		(ce_i && relay_inhibit_n_i && !wb_ack_o && keys_i == 4'h0 && $stable(pressure_i)) [*6];
	endsequence
	// ----
	// assertions
	// ----
	relay_hold_a: assert property (quiet_s |=> $stable(relay_a_o) && $stable(relay_b_o))
		else $error("relay moved with steady inputs");
	inh_off_a: assert property (inh_low_s |=> !relay_a_o && !relay_b_o)
		else $error("relay on while inhibited");
	inh_gate_a: assert property (($rose(relay_a_o) || $rose(relay_b_o)) |-> $past(relay_inhibit_n_i, 3))
		else $error("relay rose behind an inhibit");
	node_reset_a: assert property ($fell(rst_i) |-> node_id_o == 8'h01)
		else $error("node id wrong after reset");
	units_reset_a: assert property ($fell(rst_i) |-> units_o == PSRC_UNIT_TORR && lin_max_o == PSRC_RST_LIN_MAX)
		else $error("units or endpoint wrong after reset");
	defaults_back_a: assert property ($changed(units_o) |-> lin_max_o == PSRC_RST_LIN_MAX && units_o != 2'h3)
		else $error("units change kept old endpoint");
	zero_src_a: assert property (($changed(zero_point_o) && !$past(rst_i)) |-> zero_point_o == $past(sensor_raw_i) || $past(wb_ack_o && wb_we_i))
		else $error("zero point not from sensor");
	bus_ack_a: assert property ($rose(wb_stb_i) && wb_cyc_i && ce_i |=> wb_ack_o)
		else $error("ack late");
	ack_drop_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held too long");
endmodule : psrc_checker

bind psrc_top psrc_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .pressure_i(pressure_i),
	.sensor_raw_i(sensor_raw_i), .zero_point_o(zero_point_o), .lin_max_o(lin_max_o),
	.units_o(units_o), .node_id_o(node_id_o), .keys_i(keys_i),
	.relay_inhibit_n_i(relay_inhibit_n_i), .relay_a_o(relay_a_o), .relay_b_o(relay_b_o));

// ### tb.sv
// tb: self-checking bench for the setpoint relay control block.
// assumes psrc_pkg, psrc_plant, psrc_top and the bound checker are compiled first.
`timescale 1ns/10ps
module tb;
	import psrc_pkg::*;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, relay_inhibit_n_i, slow;
	logic wb_ack_o, relay_a_o, relay_b_o, irq_o;
	logic [7:0] wb_adr_i, node_id_o;
	logic [3:0] wb_sel_i, keys_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [1:0] units_o;
	logic [PSRC_PW-1:0] target, pressure_i, sensor_raw_i, zero_point_o, span_cal_o, lin_min_o, lin_max_o;
	int mismatches, samples_checked, cycles;
	logic [7:0] ids [4] = '{8'h05, 8'h0f, 8'h50, 8'hf0};

	psrc_plant i_plant (.clk_i(clk_i), .slow_i(slow), .target_i(target), .pressure_o(pressure_i),
		.raw_o(sensor_raw_i));
	psrc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pressure_i(pressure_i),
		.sensor_raw_i(sensor_raw_i), .zero_point_o(zero_point_o), .span_cal_o(span_cal_o),
		.lin_min_o(lin_min_o), .lin_max_o(lin_max_o), .units_o(units_o), .node_id_o(node_id_o),
		.keys_i(keys_i), .relay_inhibit_n_i(relay_inhibit_n_i), .relay_a_o(relay_a_o),
		.relay_b_o(relay_b_o), .irq_o(irq_o));

	// ----
	// clock and hang guard
	// ----
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// whole run needs under a thousand cycles; the ceiling leaves ample room
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR at %0t: timeout", $time);
			give_verdict();
		end
	end

	// ----
	// shared tasks
	// ----
	task give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle; request held until ack is sampled high
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20) chk(32'h0, 32'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, 1'b1, d);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask : rdc
	// key held past the two sync flops, then released as long
	task press(input int k);
		keys_i[k] <= 1'b1;
		repeat (4) @(posedge clk_i);
		keys_i <= 4'h0;
		repeat (4) @(posedge clk_i);
	endtask : press
	// wait for the chamber, then sync and relay flop
	task go(input logic [PSRC_PW-1:0] p);
		int n;
		n = 0;
		target <= p;
		@(posedge clk_i);
		while (pressure_i !== p && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		repeat (5) @(posedge clk_i);
	endtask : go

	// ----
	// scenarios
	// ----
	task t_defaults();
		rdc(PSRC_OFF_UNITS, 32'h0);
		rdc(PSRC_OFF_A_ON, 32'(PSRC_RST_ENERGIZE));
		rdc(PSRC_OFF_B_ON, 32'(PSRC_RST_ENERGIZE));
		rdc(PSRC_OFF_A_OFF, 32'(PSRC_RST_RELEASE));
		rdc(PSRC_OFF_B_OFF, 32'(PSRC_RST_RELEASE));
		rdc(PSRC_OFF_NODE, 32'h00000101);
		wr(8'h3c, 32'hffffffff);
		rdc(8'h3c, 32'h0);
		wr(PSRC_OFF_RELAY, 32'h7);
		rdc(PSRC_OFF_RELAY, 32'h0);
		$display("test defaults done");
	endtask : t_defaults
	task t_node();
		for (int i = 0; i < 4; i++) begin
			wr(PSRC_OFF_NODE, {24'h0, ids[i]});
			chk(32'(node_id_o), 32'(ids[i]));
			rdc(PSRC_OFF_NODE, {16'h0, ids[i], ids[i]});
		end
		wr(PSRC_OFF_NODE, 32'h1);
		$display("test node done");
	endtask : t_node
	// slow pumping crosses each threshold one count at a time
	task t_relay();
		wr(PSRC_OFF_MASK, 32'h1);
		slow <= 1'b1;
		go(24'd150);
		chk(32'({relay_a_o, relay_b_o}), 32'h0);
		go(24'd100);
		chk(32'({relay_a_o, relay_b_o}), 32'h0);
		go(24'd99);
		chk(32'({relay_a_o, relay_b_o, irq_o}), 32'h7);
		go(24'd200);
		chk(32'({relay_a_o, relay_b_o}), 32'h3);
		go(24'd201);
		chk(32'({relay_a_o, relay_b_o}), 32'h0);
		rdc(PSRC_OFF_STATUS, 32'h3);
		wr(PSRC_OFF_STATUS, 32'h3);
		chk(32'(irq_o), 32'h0);
		slow <= 1'b0;
		$display("test relay done");
	endtask : t_relay
	task t_inhibit();
		go(24'd50);
		ce_i <= 1'b0;
		relay_inhibit_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(32'({relay_a_o, relay_b_o}), 32'h3);
		ce_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(32'({relay_a_o, relay_b_o}), 32'h0);
		rdc(PSRC_OFF_RELAY, 32'h4);
		relay_inhibit_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(32'({relay_a_o, relay_b_o}), 32'h3);
		go(24'd500);
		$display("test inhibit done");
	endtask : t_inhibit
	task t_order();
		wr(PSRC_OFF_STATUS, 32'h1f);
		wr(PSRC_OFF_A_ON, 32'd200);
		rdc(PSRC_OFF_A_ON, 32'd100);
		wr(PSRC_OFF_A_OFF, 32'd100);
		rdc(PSRC_OFF_A_OFF, 32'd200);
		wr(PSRC_OFF_B_ON, 32'd250);
		rdc(PSRC_OFF_B_ON, 32'd100);
		wr(PSRC_OFF_B_OFF, 32'd300);
		wr(PSRC_OFF_B_ON, 32'd250);
		rdc(PSRC_OFF_B_ON, 32'd250);
		wr(PSRC_OFF_B_OFF, 32'd250);
		rdc(PSRC_OFF_B_OFF, 32'd300);
		rdc(PSRC_OFF_STATUS, 32'h4);
		$display("test order done");
	endtask : t_order
	task t_units();
		wr(PSRC_OFF_STATUS, 32'h1f);
		wr(PSRC_OFF_LIN_MAX, 32'h500);
		wr(PSRC_OFF_LIN_MIN, 32'h2);
		rdc(PSRC_OFF_LIN_MAX, 32'h500);
		wr(PSRC_OFF_UNITS, 32'h1);
		rdc(PSRC_OFF_B_ON, 32'd100);
		rdc(PSRC_OFF_B_OFF, 32'd200);
		chk(32'(lin_max_o), 32'(PSRC_RST_LIN_MAX));
		chk(32'(lin_min_o), 32'(PSRC_RST_LIN_MIN));
		wr(PSRC_OFF_UNITS, 32'h3);
		rdc(PSRC_OFF_UNITS, 32'h1);
		wr(PSRC_OFF_UNITS, 32'h2);
		chk(32'(units_o), 32'(PSRC_UNIT_PA));
		rdc(PSRC_OFF_STATUS, 32'h8);
		wr(PSRC_OFF_UNITS, 32'h0);
		$display("test units done");
	endtask : t_units
	task t_panel();
		press(PSRC_KEY_DOWN);
		press(PSRC_KEY_UP);
		press(PSRC_KEY_STORE);
		chk(32'(units_o), 32'(PSRC_UNIT_MBAR));
		press(PSRC_KEY_SCROLL);
		press(PSRC_KEY_SCROLL);
		press(PSRC_KEY_UP);
		chk(32'(zero_point_o), 32'(target + 24'h000123));
		press(PSRC_KEY_SCROLL);
		press(PSRC_KEY_UP);
		press(PSRC_KEY_UP);
		press(PSRC_KEY_STORE);
		chk(32'(span_cal_o), 32'(PSRC_RST_SPAN + 24'h000002));
		rdc(PSRC_OFF_STATUS, 32'h18);
		wr(PSRC_OFF_UNITS, 32'h0);
		$display("test panel done");
	endtask : t_panel

	// ----
	// main sequence
	// ----
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		keys_i = 4'h0;
		relay_inhibit_n_i = 1'b1;
		slow = 1'b0;
		target = 24'd500;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_defaults();
		t_node();
		t_relay();
		t_inhibit();
		t_order();
		t_units();
		t_panel();
		// second reset in mid-run must bring the unit, threshold and node defaults back
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_defaults();
		give_verdict();
	end
endmodule : tb
